// [logic/fcmc_pkg.sv]
// constants, modes and register layout of the clock mode controller
`default_nettype none
package fcmc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_FILT = 8'h08;
  localparam logic [7:0] ADDR_TRIM = 8'h0C;
  // mode request codes
  localparam logic [1:0] REQ_SELF = 2'h0;
  localparam logic [1:0] REQ_INT  = 2'h1;
  localparam logic [1:0] REQ_BYP  = 2'h2;
  localparam logic [1:0] REQ_EXT  = 2'h3;
  // reset values
  localparam logic [11:0] FILTER_RESET = 12'h200;
  localparam logic [7:0]  TRIM_RESET   = 8'h80;
  // reference period in half units: nominal 0x200, trim spans 0x180..0x27F (-25%..just under +25%)
  localparam logic [9:0]  IRG_BASE     = 10'h180;
  // crystal start-up edge count
  localparam logic [12:0] XTAL_COUNT   = 13'h1000;
  // lock detector windows and sample count; averaging, stability, divider width and loss status bit
  localparam logic [8:0]  N_LOCK       = 9'h004;
  localparam logic [8:0]  N_UNLOCK     = 9'h008;
  localparam logic [3:0]  LOCK_SAMPLES = 4'h4;
  localparam logic [1:0]  AVG_LAST     = 2'h3;
  localparam logic [1:0]  STABLE_NEED  = 2'h2;
  localparam int          DIV_W        = 9;
  localparam int          STAT_LOSS    = 5;

  typedef enum logic [2:0] {
    MODE_SELF = 3'h0,
    MODE_INT  = 3'h1,
    MODE_EXT  = 3'h3,
    MODE_BYP  = 3'h2,
    MODE_OFF  = 3'h6
  } fcmc_mode_t;

  typedef struct packed {
    logic [2:0] multiplier_field;
    logic [2:0] r_sel;
    logic       osc_in_stop_enable;
    logic       range_high;
    logic       ref_select;
    logic [1:0] mode_request;
  } fcmc_ctrl_t;

  typedef struct packed {
    logic       xtal_ok;
    logic       clock_loss_flag;
    logic       ref_valid_flag;
    logic       osc_stable_flag;
    logic       lock;
    logic [1:0] mode_status;
  } fcmc_stat_t;

  localparam fcmc_ctrl_t CTRL_RESET = 11'h000;
endpackage : fcmc_pkg
`default_nettype wire

// [logic/fcmc_div.sv]
// output divider: one pulse per R (or 2R) source ticks, gated
`timescale 1ns/1ns
`default_nettype none
module fcmc_div (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // source and setting
  input  wire logic       src_tick,
  input  wire logic [2:0] r_sel,
  input  wire logic       halve,
  input  wire logic       gate_on,
  // divided output
  output logic            tick_q
);
  import fcmc_pkg::*;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] div;

  assign div = (9'h001 << r_sel) << halve;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!gate_on) begin
        cnt_q <= '0;
      end else if (src_tick) begin
        if (cnt_q >= div - 9'h001) begin
          cnt_q  <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
      end
    end
  end
endmodule : fcmc_div
`default_nettype wire

// [logic/fcmc_top.sv]
// clock mode controller: mode state machine, lock tracking, apb registers
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fcmc_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // chip control
  input  wire logic        stop_req,
  input  wire logic        debug_enable,
  input  wire logic        ctl_reset,
  // clock pins and monitors
  input  wire logic        ext_ref_clock,
  input  wire logic        osc_clock,
  input  wire logic        ref_detect,
  input  wire logic        loss_event,
  input  wire logic [7:0]  count_err,
  input  wire logic        err_valid,
  // generator controls
  output logic             sys_clock_out,
  output logic             osc_enable,
  output logic             irg_enable,
  output logic             xtal_select,
  output logic             range_high,
  output logic [2:0]       multiplier_field,
  output logic [11:0]      filter_value,
  output logic [9:0]       irg_period
);
  import fcmc_pkg::*;

  fcmc_ctrl_t       ctrl_q;
  fcmc_stat_t       stat;
  fcmc_mode_t       state_q;
  fcmc_mode_t       state_d;
  logic [11:0]      filter_q;
  logic [7:0]       trim_q;
  logic [2:0]       s1_q;
  logic [2:0]       s2_q;
  logic [1:0]       s3_q;
  logic             ext_edge;
  logic             osc_edge;
  logic             ref_det;
  logic [9:0]       irg_cnt_q;
  logic             irg_tick_q;
  logic [12:0]      xtal_cnt_q;
  logic             ref_ok;
  logic             stop_off;
  logic             upd;
  logic             lost;
  logic             fallback;
  logic             ref_at_off_q;
  logic             wait_dco_q;
  logic             loss_q;
  logic signed [7:0] prev_err_q;
  logic [1:0]       calm_q;
  logic             osc_seen_q;
  logic             osc_stable_q;
  logic             lock_q;
  logic             was_locked_q;
  logic [3:0]       lock_cnt_q;
  logic signed [9:0] acc_q;
  logic [1:0]       avg_cnt_q;
  logic             engaged;
  logic             gate_on;
  logic [3:0]       hit;
  logic [31:0]      rd_d;
  logic [31:0]      prdata_q;
  logic             wr;
  logic [8:0]       err_mag;
  logic [8:0]       step_mag;
  logic signed [9:0] acc_sum;
  logic [7:0]       step;

  function automatic logic [3:0] fcmc_dec(input logic [7:0] a);
    fcmc_dec = {a == ADDR_TRIM, a == ADDR_FILT, a == ADDR_STAT, a == ADDR_CTRL};
  endfunction : fcmc_dec

  function automatic logic [8:0] fcmc_abs9(input logic signed [8:0] v);
    fcmc_abs9 = v[8] ? 9'(-v) : v;
  endfunction : fcmc_abs9

  function automatic logic [1:0] fcmc_status(input fcmc_mode_t m);
    fcmc_status = (m == MODE_OFF) ? REQ_SELF : m[1:0];
  endfunction : fcmc_status

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 2'h0;
    end else begin
      s1_q <= {ref_detect, osc_clock, ext_ref_clock};
      s2_q <= s1_q;
      s3_q <= s2_q[1:0];
    end
  end
  assign ext_edge = s2_q[0] & ~s3_q[0];
  assign osc_edge = s2_q[1] & ~s3_q[1];
  assign ref_det  = s2_q[2];

  // internal reference tick, period set by trim
  assign irg_period = IRG_BASE + {2'h0, trim_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irg_cnt_q  <= 10'h000;
      irg_tick_q <= 1'b0;
    end else begin
      irg_tick_q <= 1'b0;
      if (irg_cnt_q >= irg_period) begin
        irg_cnt_q  <= 10'h000;
        irg_tick_q <= 1'b1;
      end else begin
        irg_cnt_q <= irg_cnt_q + 10'h001;
      end
    end
  end

  // crystal start-up counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_cnt_q <= 13'h0000;
    end else if (ctl_reset || state_q == MODE_OFF || !ctrl_q.ref_select) begin
      xtal_cnt_q <= 13'h0000;
    end else if (ext_edge && !xtal_cnt_q[12]) begin
      xtal_cnt_q <= xtal_cnt_q + 13'h0001;
    end
  end
  assign ref_ok = ref_det & (~ctrl_q.ref_select | (xtal_cnt_q == XTAL_COUNT));

  assign stop_off = stop_req & ~debug_enable & ~ctrl_q.osc_in_stop_enable;
  assign upd      = irg_tick_q | (stop_off & (state_q != MODE_OFF));
  assign lost     = ctrl_q.mode_request[1] & ~ref_ok & loss_q;
  assign engaged  = (state_q == MODE_INT) | (state_q == MODE_EXT);

  // next mode
  always_comb begin
    state_d = state_q;
    case (state_q)
      MODE_OFF: begin
        if (!stop_off) begin
          state_d = (ctrl_q.mode_request == REQ_BYP && ref_at_off_q) ? MODE_BYP : MODE_SELF;
        end
      end
      MODE_SELF: begin
        if (ctrl_q.mode_request == REQ_BYP && ref_ok) begin
          state_d = MODE_BYP;
        end else if (ctrl_q.mode_request == REQ_EXT && ref_ok && osc_stable_q) begin
          state_d = MODE_EXT;
        end else if (ctrl_q.mode_request == REQ_INT && (!wait_dco_q || osc_stable_q)) begin
          state_d = MODE_INT;
        end
      end
      MODE_INT: begin
        if (ctrl_q.mode_request == REQ_SELF) begin
          state_d = MODE_SELF;
        end else if (ctrl_q.mode_request == REQ_EXT && ref_ok && osc_stable_q) begin
          state_d = MODE_EXT;
        end else if (ctrl_q.mode_request == REQ_BYP && ref_ok) begin
          state_d = MODE_BYP;
        end
      end
      MODE_BYP: begin
        if (ctrl_q.mode_request == REQ_SELF) begin
          state_d = MODE_SELF;
        end else if (ctrl_q.mode_request == REQ_INT) begin
          state_d = MODE_INT;
        end else if (ctrl_q.mode_request == REQ_EXT && ref_ok && osc_stable_q) begin
          state_d = MODE_EXT;
        end
      end
      MODE_EXT: begin
        if (ctrl_q.mode_request == REQ_SELF) begin
          state_d = MODE_SELF;
        end else if (loss_q && ref_ok) begin
          state_d = MODE_BYP;
        end else if (ctrl_q.mode_request == REQ_INT) begin
          state_d = MODE_INT;
        end else if (ctrl_q.mode_request == REQ_BYP) begin
          state_d = MODE_BYP;
        end
      end
      default: state_d = MODE_SELF;
    endcase
    if (lost && state_q != MODE_OFF) begin
      state_d = MODE_SELF;
    end
    if (stop_off) begin
      state_d = MODE_OFF;
    end
  end

  assign fallback = upd & (state_d != state_q) & (lost | (state_q == MODE_EXT & state_d == MODE_BYP & loss_q));

  // mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MODE_SELF;
    end else if (ctl_reset) begin
      state_q <= MODE_SELF;
    end else if (upd) begin
      state_q <= state_d;
    end
  end

  // off entry memory and post-off wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_at_off_q <= 1'b0;
      wait_dco_q   <= 1'b0;
    end else if (ctl_reset) begin
      ref_at_off_q <= 1'b0;
      wait_dco_q   <= 1'b0;
    end else if (upd) begin
      if (state_q != MODE_OFF && state_d == MODE_OFF) begin
        ref_at_off_q <= (ctrl_q.mode_request == REQ_BYP) & ref_ok;
      end
      if (state_q == MODE_OFF && state_d == MODE_SELF) begin
        wait_dco_q <= 1'b1;
      end else if (state_d != MODE_SELF) begin
        wait_dco_q <= 1'b0;
      end
    end
  end

  // sticky clock loss; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_q <= 1'b0;
    end else if (loss_event) begin
      loss_q <= 1'b1;
    end else if (wr && hit[1] && pwdata[STAT_LOSS]) begin
      loss_q <= 1'b0;
    end
  end

  // oscillator stable detector
  assign step_mag = fcmc_abs9($signed({count_err[7], count_err}) - $signed({prev_err_q[7], prev_err_q}));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_err_q   <= 8'sh00;
      calm_q       <= 2'h0;
      osc_seen_q   <= 1'b0;
      osc_stable_q <= 1'b0;
    end else if (state_q == MODE_OFF) begin
      calm_q       <= 2'h0;
      osc_seen_q   <= 1'b0;
      osc_stable_q <= 1'b0;
    end else begin
      if (osc_edge) begin
        osc_seen_q <= 1'b1;
      end
      if (err_valid) begin
        prev_err_q <= count_err;
        osc_seen_q <= osc_edge;
        if (step_mag <= N_UNLOCK && (osc_seen_q || osc_edge)) begin
          if (calm_q != STABLE_NEED) begin
            calm_q <= calm_q + 2'h1;
          end
          if (calm_q == STABLE_NEED - 2'h1) begin
            osc_stable_q <= 1'b1;
          end
        end else begin
          calm_q <= 2'h0;
        end
      end
    end
  end

  // lock detection
  assign err_mag = fcmc_abs9($signed({count_err[7], count_err}));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q       <= 1'b0;
      lock_cnt_q   <= 4'h0;
      was_locked_q <= 1'b0;
    end else if (!engaged) begin
      lock_q       <= 1'b0;
      lock_cnt_q   <= 4'h0;
      was_locked_q <= 1'b0;
    end else if (err_valid) begin
      if (!lock_q) begin
        if (err_mag < N_LOCK) begin
          lock_cnt_q <= lock_cnt_q + 4'h1;
          if (lock_cnt_q == LOCK_SAMPLES - 4'h1) begin
            lock_q       <= 1'b1;
            was_locked_q <= 1'b1;
          end
        end else begin
          lock_cnt_q <= 4'h0;
        end
      end else if (err_mag >= N_UNLOCK) begin
        lock_q     <= 1'b0;
        lock_cnt_q <= 4'h0;
      end
    end
  end

  // loop filter, averaged over four samples once locked
  assign acc_sum = acc_q + $signed({{2{count_err[7]}}, count_err});
  assign step    = lock_q ? acc_sum[9:2] : count_err;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_q  <= FILTER_RESET;
      acc_q     <= 10'sh000;
      avg_cnt_q <= 2'h0;
    end else if (ctl_reset) begin
      filter_q  <= FILTER_RESET;
      acc_q     <= 10'sh000;
      avg_cnt_q <= 2'h0;
    end else if (wr && hit[2]) begin
      if (state_q == MODE_SELF && ctrl_q.mode_request == REQ_SELF) begin
        filter_q <= pwdata[11:0];
      end
    end else if (engaged && err_valid) begin
      if (!lock_q) begin
        filter_q  <= filter_q + {{4{step[7]}}, step};
        avg_cnt_q <= 2'h0;
        acc_q     <= 10'sh000;
      end else if (avg_cnt_q == AVG_LAST) begin
        filter_q  <= filter_q + {{4{step[7]}}, step};
        avg_cnt_q <= 2'h0;
        acc_q     <= 10'sh000;
      end else begin
        acc_q     <= acc_sum;
        avg_cnt_q <= avg_cnt_q + 2'h1;
      end
    end
  end

  // control and trim registers
  assign wr = psel & penable & pwrite;
  assign hit = fcmc_dec(paddr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctl_reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr && hit[0]) begin
      ctrl_q <= pwdata[10:0];
    end else if (fallback) begin
      ctrl_q.mode_request <= fcmc_status(state_d);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= TRIM_RESET;
    end else if (wr && hit[3]) begin
      trim_q <= pwdata[7:0];
    end
  end

  // status and read path
  assign stat = '{xtal_ok: xtal_cnt_q == XTAL_COUNT, clock_loss_flag: loss_q, ref_valid_flag: ref_ok,
                  osc_stable_flag: osc_stable_q, lock: lock_q, mode_status: fcmc_status(state_q)};
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit[0]) rd_d = {21'h000000, ctrl_q};
    if (hit[1]) rd_d = {25'h0000000, stat};
    if (hit[2]) rd_d = {20'h00000, filter_q};
    if (hit[3]) rd_d = {24'h000000, trim_q};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rd_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~|hit;

  // output gating and divider
  assign gate_on = (state_q != MODE_OFF) & ~(stop_req & ~debug_enable)
                   & ~(state_q == MODE_BYP & ~ref_ok);

  fcmc_div u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick ((state_q == MODE_BYP) ? ext_edge : osc_edge),
    .r_sel    (ctrl_q.r_sel),
    .halve    (state_q == MODE_EXT && !was_locked_q),
    .gate_on  (gate_on),
    .tick_q   (sys_clock_out)
  );

  assign osc_enable       = (state_q != MODE_OFF) & (state_q != MODE_BYP);
  assign irg_enable       = osc_enable;
  assign xtal_select      = ctrl_q.ref_select;
  assign range_high       = ctrl_q.range_high;
  assign multiplier_field = ctrl_q.multiplier_field;
  assign filter_value     = filter_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off_quiet;
    state_q == MODE_OFF ##1 state_q == MODE_OFF |-> !sys_clock_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("clock pulse while off");

  property p_debug_run;
    stop_req && debug_enable && state_q != MODE_OFF |=> state_q != MODE_OFF;
  endproperty
  a_debug_run: assert property (p_debug_run) else $error("off entered with debug on");

  property p_osc_stop;
    (stop_req && !debug_enable && ctrl_q.osc_in_stop_enable)[*2]
      |-> !sys_clock_out && (osc_enable || state_q == MODE_BYP);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("osc in stop misbehaves");

  property p_byp_hold;
    (state_q == MODE_BYP && !ref_ok)[*2] |-> !sys_clock_out;
  endproperty
  a_byp_hold: assert property (p_byp_hold) else $error("bypass output before reference");

  property p_xtal_wait;
    ctrl_q.ref_select && xtal_cnt_q != XTAL_COUNT |-> !ref_ok;
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("crystal used too early");

  property p_filt_ro;
    wr && hit[2] && state_q != MODE_SELF && !ctl_reset |=> filter_q == $past(filter_q);
  endproperty
  a_filt_ro: assert property (p_filt_ro) else $error("filter written outside self mode");

  property p_unlock_out;
    !engaged |=> !lock_q;
  endproperty
  a_unlock_out: assert property (p_unlock_out) else $error("lock outside engaged");

  property p_byp_off;
    state_q == MODE_BYP |-> !osc_enable && !irg_enable;
  endproperty
  a_byp_off: assert property (p_byp_off) else $error("sources on in bypass");

  property p_fallback;
    upd && state_q == MODE_EXT && loss_q && ref_ok && !stop_off && !ctl_reset
      && ctrl_q.mode_request != REQ_SELF |=> state_q == MODE_BYP;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no bypass fallback");

  property p_stable_clr;
    state_q == MODE_OFF |=> !osc_stable_q;
  endproperty
  a_stable_clr: assert property (p_stable_clr) else $error("stable flag kept in off");

  property p_status;
    state_q == MODE_INT |-> stat.mode_status == REQ_INT;
  endproperty
  a_status: assert property (p_status) else $error("wrong mode status");

  c_ext_lock: cover property (state_q == MODE_EXT && lock_q);
  c_bypass: cover property (state_q == MODE_BYP && sys_clock_out);
  c_off_exit: cover property (state_q == MODE_OFF ##1 state_q == MODE_SELF);
endmodule : fcmc_top
`default_nettype wire

// [tb/fcmc_xsrc.sv]
// external reference and oscillator source model
`timescale 1ns/1ns
`default_nettype none
module fcmc_xsrc (
  // control
  input  wire logic pclk,
  input  wire logic run,
  // source pins
  output logic      ext_ref_clock,
  output logic      osc_clock,
  output logic      ref_detect
);
  logic [2:0] cnt_q = 3'h0;
  logic       osc_q = 1'b0;
  logic       ext_q = 1'b0;
  // reference stands low while stopped
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 3'h1;
    osc_q <= ~osc_q;
    ext_q <= run & cnt_q[2];
  end
  assign osc_clock     = osc_q;
  assign ext_ref_clock = ext_q;
  assign ref_detect    = run;
endmodule : fcmc_xsrc
`default_nettype wire

// [tb/tb_top.sv]
// bench: apb access, stop, modes, trim, lock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fcmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se, run;
  logic        stop_req, debug_enable, ctl_reset, ext_ref_clock, osc_clock;
  logic        ref_detect, loss_event, err_valid, sys_clock_out;
  logic        osc_enable, irg_enable, xtal_select, range_high;
  logic [7:0]  paddr, count_err;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  multiplier_field;
  logic [11:0] filter_value;
  logic [9:0]  irg_period;
  int          err_total, checked, np;
  fcmc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stop_req, .debug_enable, .ctl_reset, .ext_ref_clock, .osc_clock,
    .ref_detect, .loss_event, .count_err, .err_valid, .sys_clock_out, .osc_enable,
    .irg_enable, .xtal_select, .range_high, .multiplier_field, .filter_value, .irg_period);
  fcmc_xsrc src (.pclk, .run, .ext_ref_clock, .osc_clock, .ref_detect);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask : apb
  task automatic wait_mode(input logic [1:0] m);
    int i;
    for (i = 0; i < 500; i++) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (rd[1:0] === m) break;
    end
    if (i == 500) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_mode
  task automatic pulses(input int c);
    np = 0;
    @(posedge pclk);
    repeat (c) @(negedge pclk) np += int'(sys_clock_out === 1'b1);
    @(posedge pclk);
  endtask : pulses
  task automatic pulse_err(input logic [7:0] e);
    @(posedge pclk);
    count_err <= e;
    err_valid <= 1'b1;
    @(posedge pclk);
    err_valid <= 1'b0;
  endtask : pulse_err
  task automatic t_reset;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, ADDR_FILT, 32'h0);
    chk("filter", 32'h200, rd);
    apb(1'b0, ADDR_TRIM, 32'h0);
    chk("trim", 32'h80, rd);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("mode", 32'h0, {30'h0, rd[1:0]});
    chk("period", 32'h200, {22'h0, irg_period});
    $display("reset test done");
  endtask : t_reset
  task automatic t_trim;
    apb(1'b1, ADDR_TRIM, 32'hFF);
    @(negedge pclk);
    chk("period max", 32'h27F, {22'h0, irg_period});
    apb(1'b1, ADDR_TRIM, 32'h00);
    @(negedge pclk);
    chk("period min", 32'h180, {22'h0, irg_period});
    apb(1'b1, ADDR_TRIM, 32'h81);
    $display("trim test done");
  endtask : t_trim
  task automatic t_regs;
    apb(1'b1, ADDR_FILT, 32'h123);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_FILT, 32'h456);
    apb(1'b0, ADDR_FILT, 32'h0);
    chk("filter", 32'h123, rd);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    loss_event <= 1'b1;
    @(posedge pclk);
    loss_event <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("loss", 32'h1, {31'h0, rd[5]});
    apb(1'b1, ADDR_STAT, 32'h20);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("loss clr", 32'h0, {31'h0, rd[5]});
    $display("register test done");
  endtask : t_regs
  task automatic t_stop;
    apb(1'b1, ADDR_CTRL, 32'h10);
    stop_req <= 1'b1;
    pulses(30);
    chk("osc in stop", 32'h1, {31'h0, osc_enable});
    chk("gated", 32'h0, np);
    stop_req <= 1'b0;
    debug_enable <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h0);
    stop_req <= 1'b1;
    pulses(30);
    chk("debug run", 32'h1, {31'h0, np > 0});
    debug_enable <= 1'b0;
    pulses(2);
    chk("off", 32'h0, {30'h0, osc_enable, irg_enable});
    stop_req <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h10);
    ctl_reset <= 1'b1;
    @(posedge pclk);
    ctl_reset <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, ADDR_TRIM, 32'h0);
    chk("trim kept", 32'h81, rd);
    $display("stop test done");
  endtask : t_stop
  task automatic t_bypass;
    run <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h2);
    wait_mode(2'h2);
    pulses(60);
    chk("sources", 32'h0, {30'h0, osc_enable, irg_enable});
    chk("ext out", 32'h1, {31'h0, np > 0});
    ctl_reset <= 1'b1;
    @(posedge pclk);
    ctl_reset <= 1'b0;
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_lock;
    apb(1'b1, ADDR_CTRL, 32'h50D);
    wait_mode(2'h1);
    chk("mult", 32'h5, {29'h0, multiplier_field});
    chk("lock0", 32'h0, {31'h0, rd[2]});
    chk("xtal wait", 32'h0, {30'h0, rd[6], rd[4]});
    chk("ref pins", 32'h3, {30'h0, xtal_select, range_high});
    repeat (4) pulse_err(8'hFE);
    @(negedge pclk);
    chk("unlocked filt", 32'h1F8, {20'h0, filter_value});
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("lock", 32'h1, {31'h0, rd[2]});
    repeat (3) pulse_err(8'hFC);
    @(negedge pclk);
    chk("avg hold", 32'h1F8, {20'h0, filter_value});
    pulse_err(8'hFC);
    @(negedge pclk);
    chk("avg step", 32'h1F4, {20'h0, filter_value});
    pulse_err(8'h10);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("unlock", 32'h0, {31'h0, rd[2]});
    $display("lock test done");
  endtask : t_lock
  task automatic t_ext;
    apb(1'b1, ADDR_CTRL, 32'h503);
    wait_mode(2'h3);
    chk("ext ref", 32'h1, {31'h0, rd[4]});
    loss_event <= 1'b1;
    @(posedge pclk);
    loss_event <= 1'b0;
    wait_mode(2'h2);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("req rewrite", 32'h2, {30'h0, rd[1:0]});
    $display("external test done");
  endtask : t_ext
  initial begin
    {presetn, psel, penable, pwrite, stop_req, debug_enable, ctl_reset} = 7'h0;
    {loss_event, err_valid, run, paddr, count_err, pwdata} = 51'h0;
    err_total = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trim();
    t_regs();
    t_stop();
    t_bypass();
    t_lock();
    t_ext();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
